// [verilog/dbr_dual_button_reset.sv]
// Purpose: delayed reset from two jointly held buttons, with test mode
// Assumes: inputs synchronous to SYS_CLK, RESET is the supply power-up reset
// Notes:   option bits and hold delay live in the config register
`timescale 1ns/1ps

module dbr_dual_button_reset
    import dbr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter logic [STEPS_W-1:0] HOLD_STEPS_DEF = 5'h0f,
    parameter logic [MS_W-1:0] PULSE_MS = PULSE_MS_DEF,
    parameter logic FIXED_PULSE_DEF = 1'b0,
    parameter logic ACTIVE_HIGH_DEF = 1'b0,
    parameter logic OPEN_DRAIN_DEF = 1'b1
) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic CLK_EN,
    input wire logic PRIMARY_BUTTON_N,
    input wire logic SECONDARY_BUTTON_N,
    input wire logic UNDERVOLTAGE,
    input wire logic OVERVOLTAGE,
    output logic RESET_OUT_O,
    output logic RESET_OUT_OE,
    output logic RESET_ACTIVE,
    output logic TEST_MODE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);

    // ********************************************************************
    // helpers
    // ********************************************************************
    function automatic logic [MS_W-1:0] hold_ms(input logic [STEPS_W-1:0] steps);
        logic [STEPS_W-1:0] s;
        s = steps;
        if (s < STEPS_MIN) begin
            s = STEPS_MIN;
        end else if (s > STEPS_MAX) begin
            s = STEPS_MAX;
        end
        return MS_W'(s) * HOLD_STEP_MS;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return (a == CONFIG_OFS) || (a == STATUS_OFS);
    endfunction

    // ********************************************************************
    // declarations
    // ********************************************************************
    dbr_state_t state;
    dbr_state_t next_state;
    logic test_mode;
    logic next_test_mode;
    logic [STEPS_W-1:0] cfg_steps;
    logic [STEPS_W-1:0] next_cfg_steps;
    logic cfg_fixed;
    logic next_cfg_fixed;
    logic cfg_high;
    logic next_cfg_high;
    logic cfg_od;
    logic next_cfg_od;
    logic [31:0] next_prdata;
    logic both_pressed;
    logic timer_start;
    logic timer_done;
    logic [MS_W-1:0] hold_limit;
    logic [MS_W-1:0] timer_limit;
    logic entry_start;
    logic entry_done;
    logic reset_req;
    logic wr_cfg;
    logic [31:0] status_word;

    // ********************************************************************
    // button qualification
    // ********************************************************************
    assign both_pressed = !PRIMARY_BUTTON_N && !SECONDARY_BUTTON_N && !UNDERVOLTAGE;
    assign hold_limit = test_mode ? TEST_HOLD_MS : hold_ms(cfg_steps);
    assign timer_limit = (state == ST_ARMING) ? hold_limit : PULSE_MS;
    assign timer_start = (next_state != state) || (state == ST_IDLE);
    assign entry_start = !OVERVOLTAGE || UNDERVOLTAGE || test_mode;

    // ********************************************************************
    // timers
    // ********************************************************************
    dbr_ms_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .MS_W(MS_W)
    ) u_hold_timer (
        .clk(SYS_CLK),
        .rst(RESET),
        .ce(CLK_EN),
        .start(timer_start),
        .run(1'b1),
        .limit_ms(timer_limit),
        .done(timer_done)
    );

    dbr_ms_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .MS_W(MS_W)
    ) u_entry_timer (
        .clk(SYS_CLK),
        .rst(RESET),
        .ce(CLK_EN),
        .start(entry_start),
        .run(1'b1),
        .limit_ms(TEST_ENTRY_MS),
        .done(entry_done)
    );

    // ********************************************************************
    // sequence control
    // ********************************************************************
    always_comb begin
        next_state = state;
        next_test_mode = test_mode;
        if (UNDERVOLTAGE) begin
            next_state = ST_IDLE;
        end else if (entry_done && !test_mode) begin
            next_test_mode = 1'b1;
            next_state = ST_FEEDBACK;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (both_pressed) begin
                        next_state = ST_ARMING;
                    end
                end
                ST_ARMING: begin
                    if (!both_pressed) begin
                        next_state = ST_IDLE;
                    end else if (timer_done) begin
                        next_state = cfg_fixed ? ST_PULSE : ST_HELD;
                    end
                end
                ST_HELD: begin
                    if (!both_pressed) begin
                        next_state = ST_IDLE;
                    end
                end
                ST_PULSE: begin
                    if (timer_done) begin
                        next_state = ST_WAIT_RELEASE;
                    end
                end
                ST_WAIT_RELEASE: begin
                    if (!both_pressed) begin
                        next_state = ST_IDLE;
                    end
                end
                ST_FEEDBACK: begin
                    if (cfg_fixed ? timer_done : !OVERVOLTAGE) begin
                        next_state = ST_WAIT_RELEASE;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            state <= ST_IDLE;
            test_mode <= 1'b0;
        end else if (CLK_EN) begin
            state <= next_state;
            test_mode <= next_test_mode;
        end
    end

    // ********************************************************************
    // reset output
    // ********************************************************************
    assign reset_req = !UNDERVOLTAGE && ((state == ST_HELD) || (state == ST_PULSE)
        || (state == ST_FEEDBACK));
    assign TEST_MODE = test_mode;

    dbr_reset_driver u_driver (
        .clk(SYS_CLK),
        .rst(RESET),
        .ce(CLK_EN),
        .assert_req(reset_req),
        .active_high(cfg_high && !cfg_od),
        .open_drain(cfg_od),
        .pin_o(RESET_OUT_O),
        .pin_oe(RESET_OUT_OE),
        .asserted(RESET_ACTIVE)
    );

    // ********************************************************************
    // apb registers
    // ********************************************************************
    assign wr_cfg = PSEL && PENABLE && PWRITE && CLK_EN && (PADDR == CONFIG_OFS);
    assign PREADY = CLK_EN;
    assign PSLVERR = PSEL && PENABLE && !mapped(PADDR);

    always_comb begin
        status_word = '0;
        status_word[ST_STATE_LSB +: 3] = state;
        status_word[ST_TEST_BIT] = test_mode;
        status_word[ST_ACTIVE_BIT] = RESET_ACTIVE;
        status_word[ST_PRI_BIT] = !PRIMARY_BUTTON_N;
        status_word[ST_SEC_BIT] = !SECONDARY_BUTTON_N;
        status_word[ST_UV_BIT] = UNDERVOLTAGE;
        status_word[ST_OV_BIT] = OVERVOLTAGE;
    end

    always_comb begin
        next_cfg_steps = cfg_steps;
        next_cfg_fixed = cfg_fixed;
        next_cfg_high = cfg_high;
        next_cfg_od = cfg_od;
        next_prdata = PRDATA;
        if (wr_cfg) begin
            next_cfg_steps = PWDATA[CFG_STEPS_LSB +: STEPS_W];
            next_cfg_fixed = PWDATA[CFG_FIXED_BIT];
            next_cfg_high = PWDATA[CFG_HIGH_BIT];
            next_cfg_od = PWDATA[CFG_OD_BIT];
        end
        if (PSEL && !PENABLE) begin
            if (PADDR == CONFIG_OFS) begin
                next_prdata = '0;
                next_prdata[CFG_STEPS_LSB +: STEPS_W] = cfg_steps;
                next_prdata[CFG_FIXED_BIT] = cfg_fixed;
                next_prdata[CFG_HIGH_BIT] = cfg_high;
                next_prdata[CFG_OD_BIT] = cfg_od;
            end else if (PADDR == STATUS_OFS) begin
                next_prdata = status_word;
            end else begin
                next_prdata = '0;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            cfg_steps <= HOLD_STEPS_DEF;
            cfg_fixed <= FIXED_PULSE_DEF;
            cfg_high <= ACTIVE_HIGH_DEF;
            cfg_od <= OPEN_DRAIN_DEF;
            PRDATA <= '0;
        end else if (CLK_EN) begin
            cfg_steps <= next_cfg_steps;
            cfg_fixed <= next_cfg_fixed;
            cfg_high <= next_cfg_high;
            cfg_od <= next_cfg_od;
            PRDATA <= next_prdata;
        end
    end

    // ********************************************************************
    // checks
    // ********************************************************************
    property p_hold_first;
        @(posedge SYS_CLK) disable iff (RESET)
        (CLK_EN && state == ST_ARMING && (next_state == ST_HELD || next_state == ST_PULSE))
            |-> (both_pressed && timer_done);
    endproperty
    a_hold_first: assert property (p_hold_first) else $error("reset without full hold");

    property p_hold_range;
        @(posedge SYS_CLK) disable iff (RESET)
        !test_mode |-> (hold_limit >= HOLD_MIN_MS && hold_limit <= HOLD_MAX_MS);
    endproperty
    a_hold_range: assert property (p_hold_range) else $error("hold delay out of range");

    property p_follow_release;
        @(posedge SYS_CLK) disable iff (RESET)
        (CLK_EN && state == ST_HELD && !both_pressed && !(entry_done && !test_mode))
            |=> (state == ST_IDLE) ##1 !RESET_ACTIVE;
    endproperty
    a_follow_release: assert property (p_follow_release) else $error("held reset kept");

    property p_pulse_kept;
        @(posedge SYS_CLK) disable iff (RESET)
        (CLK_EN && state == ST_PULSE && !timer_done && !UNDERVOLTAGE
            && !(entry_done && !test_mode)) |=> (state == ST_PULSE);
    endproperty
    a_pulse_kept: assert property (p_pulse_kept) else $error("fixed pulse cut short");

    property p_uv_release;
        @(posedge SYS_CLK) disable iff (RESET)
        (CLK_EN && UNDERVOLTAGE) |=> (!RESET_ACTIVE && state == ST_IDLE);
    endproperty
    a_uv_release: assert property (p_uv_release) else $error("output active in undervoltage");

    property p_entry_idle;
        @(posedge SYS_CLK) disable iff (RESET)
        (CLK_EN && !OVERVOLTAGE) |=> !entry_done;
    endproperty
    a_entry_idle: assert property (p_entry_idle) else $error("entry timer without overvoltage");

    property p_test_enter;
        @(posedge SYS_CLK) disable iff (RESET)
        (CLK_EN && entry_done && !test_mode && !UNDERVOLTAGE)
            |=> (test_mode && state == ST_FEEDBACK) ##1 (RESET_ACTIVE || !CLK_EN);
    endproperty
    a_test_enter: assert property (p_test_enter) else $error("test entry feedback missing");

    property p_feedback_hold;
        @(posedge SYS_CLK) disable iff (RESET)
        (CLK_EN && state == ST_FEEDBACK && !cfg_fixed && OVERVOLTAGE && !UNDERVOLTAGE)
            |=> (state == ST_FEEDBACK);
    endproperty
    a_feedback_hold: assert property (p_feedback_hold) else $error("feedback ended early");

    property p_short_hold;
        @(posedge SYS_CLK) disable iff (RESET)
        test_mode |-> (hold_limit == TEST_HOLD_MS);
    endproperty
    a_short_hold: assert property (p_short_hold) else $error("test hold delay wrong");

    property p_test_latched;
        @(posedge SYS_CLK) disable iff (RESET)
        test_mode |=> test_mode;
    endproperty
    a_test_latched: assert property (p_test_latched) else $error("test mode left");

    property p_restart;
        @(posedge SYS_CLK) disable iff (RESET)
        (CLK_EN && state == ST_ARMING && !both_pressed && !(entry_done && !test_mode))
            |=> (state == ST_IDLE);
    endproperty
    a_restart: assert property (p_restart) else $error("hold count not restarted");

    property p_need_release;
        @(posedge SYS_CLK) disable iff (RESET)
        (CLK_EN && state == ST_WAIT_RELEASE && both_pressed && !(entry_done && !test_mode))
            |=> (state == ST_WAIT_RELEASE);
    endproperty
    a_need_release: assert property (p_need_release) else $error("rearmed without release");

endmodule // dbr_dual_button_reset

// [common/dbr_pkg.sv]
// Purpose: shared constants and types for the dual button delayed reset block
// Assumes: 40 MHz system clock, one millisecond internal time base
// Notes:   register offsets are byte addresses on the apb bus

package dbr_pkg;

    // ********************************************************************
    // timing
    // ********************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int MS_W = 14;
    localparam logic [MS_W-1:0] HOLD_STEP_MS = 14'h01f4;
    localparam logic [MS_W-1:0] HOLD_MIN_MS = 14'h01f4;
    localparam logic [MS_W-1:0] HOLD_MAX_MS = 14'h2710;
    localparam logic [MS_W-1:0] TEST_ENTRY_MS = 14'h002a;
    localparam logic [MS_W-1:0] TEST_HOLD_MS = 14'h0015;
    localparam logic [MS_W-1:0] PULSE_MS_DEF = 14'h00c8;

    // ********************************************************************
    // register map
    // ********************************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CONFIG_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam int STEPS_W = 5;
    localparam logic [STEPS_W-1:0] STEPS_MIN = 5'h01;
    localparam logic [STEPS_W-1:0] STEPS_MAX = 5'h14;
    localparam int CFG_STEPS_LSB = 0;
    localparam int CFG_FIXED_BIT = 5;
    localparam int CFG_HIGH_BIT = 6;
    localparam int CFG_OD_BIT = 7;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_TEST_BIT = 3;
    localparam int ST_ACTIVE_BIT = 4;
    localparam int ST_PRI_BIT = 5;
    localparam int ST_SEC_BIT = 6;
    localparam int ST_UV_BIT = 7;
    localparam int ST_OV_BIT = 8;

    // ********************************************************************
    // types
    // ********************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMING,
        ST_HELD,
        ST_PULSE,
        ST_WAIT_RELEASE,
        ST_FEEDBACK
    } dbr_state_t;

endpackage

// [verilog/dbr_ms_timer.sv]
// Purpose: millisecond interval timer with its own prescaler
// Assumes: start clears both counters, run lets them advance
// Notes:   done is high once limit_ms whole milliseconds have passed
`timescale 1ns/1ps

module dbr_ms_timer #(
    parameter int TICK_CYCLES = 40000,
    parameter int MS_W = 14
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic run,
    input wire logic [MS_W-1:0] limit_ms,
    output logic done
);
    localparam int PRE_W = $clog2(TICK_CYCLES) + 1;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

    logic [PRE_W-1:0] pre;
    logic [PRE_W-1:0] next_pre;
    logic [MS_W-1:0] ms;
    logic [MS_W-1:0] next_ms;

    assign done = (ms >= limit_ms);

    // ********************************************************************
    // counting
    // ********************************************************************
    always_comb begin
        next_pre = pre;
        next_ms = ms;
        if (start) begin
            next_pre = '0;
            next_ms = '0;
        end else if (run && !done) begin
            if (pre == PRE_LAST) begin
                next_pre = '0;
                next_ms = ms + 1'b1;
            end else begin
                next_pre = pre + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre <= '0;
            ms <= '0;
        end else if (ce) begin
            pre <= next_pre;
            ms <= next_ms;
        end
    end

endmodule // dbr_ms_timer

// [verilog/dbr_reset_driver.sv]
// Purpose: reset pin driver with selectable polarity and output style
// Assumes: open drain output only ever pulls low
// Notes:   pin level and enable come from flip-flops
`timescale 1ns/1ps

module dbr_reset_driver (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic assert_req,
    input wire logic active_high,
    input wire logic open_drain,
    output logic pin_o,
    output logic pin_oe,
    output logic asserted
);
    logic next_asserted;
    logic next_pin_o;
    logic next_pin_oe;

    // ********************************************************************
    // pin level
    // ********************************************************************
    always_comb begin
        next_asserted = !rst && assert_req;
        if (open_drain) begin
            next_pin_o = 1'b0;
            next_pin_oe = next_asserted;
        end else begin
            next_pin_o = active_high ? next_asserted : !next_asserted;
            next_pin_oe = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || ce) begin
            asserted <= next_asserted;
            pin_o <= next_pin_o;
            pin_oe <= next_pin_oe;
        end
    end

    property p_od_low;
        @(posedge clk) disable iff (rst)
        (ce && open_drain) |=> (!pin_o && (pin_oe == asserted));
    endproperty
    a_od_low: assert property (p_od_low) else $error("open drain pin not pulling low");

endmodule // dbr_reset_driver

// [test/dbr_button_model.sv]
// Purpose: two push-buttons and the processor reset input
// Assumes: pull-ups on both buttons and on the reset line
// Notes:   cpu_reset is high while the processor sees reset
`timescale 1ns/1ps

module dbr_button_model (
    input wire logic pri_press,
    input wire logic sec_press,
    input wire logic active_high,
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic pri_n,
    output logic sec_n,
    output logic cpu_reset
);
    logic pin_level;
    // ****************************************************************
    // released buttons and an undriven pin float to the pull-up level
    // ****************************************************************
    assign pri_n = pri_press ? 1'b0 : 1'b1;
    assign sec_n = sec_press ? 1'b0 : 1'b1;
    assign pin_level = pin_oe ? pin_o : 1'b1;
    assign cpu_reset = active_high ? pin_level : ~pin_level;
endmodule // dbr_button_model

// [test/testbench.sv]
// Purpose: self-checking bench for the dual button delayed reset
// Assumes: four clocks per millisecond tick
// Notes:   registers reached over apb, buttons through the model
`timescale 1ns/1ps

module testbench;
    import dbr_pkg::*;
    localparam int T = 4;
    logic clk = 1'b0, rst = 1'b1, uv = 1'b0, ov = 1'b0, pp = 1'b0, sp = 1'b0, ah = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, ro, roe, ract, tmode, pready, perr, cpu, pn, sn;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int fails = 0, check_count = 0, n, k;
    logic [4:0] steps [2] = '{5'h01, 5'h14};

    always #12.5 clk = ~clk;

    dbr_dual_button_reset #(.TICK_CYCLES(T)) u_dut (.SYS_CLK(clk), .RESET(rst), .CLK_EN(1'b1),
        .PRIMARY_BUTTON_N(pn), .SECONDARY_BUTTON_N(sn), .UNDERVOLTAGE(uv), .OVERVOLTAGE(ov),
        .RESET_OUT_O(ro), .RESET_OUT_OE(roe), .RESET_ACTIVE(ract), .TEST_MODE(tmode),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr));
    dbr_button_model u_btn (.pri_press(pp), .sec_press(sp), .active_high(ah), .pin_o(ro),
        .pin_oe(roe), .pri_n(pn), .sec_n(sn), .cpu_reset(cpu));

    // ****************************************************************
    // checking and closing
    // ****************************************************************
    task automatic end_of_test();
        if (fails == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask

    // waits for RESET_ACTIVE (sel 0) or TEST_MODE (sel 1) to reach val, counting edges
    task automatic wait_sig(input int sel, input logic val, input int max, output int c);
        c = 0;
        while (((sel == 0) ? ract : tmode) !== val) begin
            @(posedge clk);
            c++;
            if (c > max) begin
                check(c, max, "wait bound");
                end_of_test();
            end
        end
    endtask

    // ****************************************************************
    // apb master
    // ****************************************************************
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int w;
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        w = 0;
        do begin
            @(posedge clk);
            w++;
            if (w > 20) begin
                check(w, 20, "pready wait");
                end_of_test();
            end
        end while (pready !== 1'b1);
        q = prdata;
        e = perr;
        psel <= 1'b0; pen <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        logic e;
        apb(1'b0, a, 32'h0, rd, e);
        check(rd, exp, "read data");
        check(e, eexp, "slave error");
    endtask

    task automatic press(input logic p, input logic s);
        pp <= p; sp <= s;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        logic e;
        cyc(12);
        rst <= 1'b0;
        rd_chk(CONFIG_OFS, 32'h0000008f, 1'b0);
        rd_chk(STATUS_OFS, 32'h00000000, 1'b0);
        rd_chk(8'h08, 32'h00000000, 1'b1);
        apb(1'b1, STATUS_OFS, 32'h000000ff, rd, e);
        rd_chk(STATUS_OFS, 32'h00000000, 1'b0);
        check(cpu, 1'b0, "idle pin");
        for (k = 0; k < 2; k++) begin
            apb(1'b1, CONFIG_OFS, {27'h0, steps[k]}, rd, e);
            rd_chk(CONFIG_OFS, {27'h0, steps[k]}, 1'b0);
            press(1'b1, 1'b1);
            cyc(1000);
            press(1'b1, 1'b0);
            cyc(5);
            check(ract, 1'b0, "short press");
            press(1'b1, 1'b1);
            wait_sig(0, 1'b1, 45000, n);
            check(n > steps[k] * 500 * T - 2 && n < steps[k] * 500 * T + 6, 1, "hold");
            check(cpu, 1'b1, "pin low push pull");
            press(1'b0, 1'b1);
            wait_sig(0, 1'b0, 4, n);
            press(1'b0, 1'b0);
            cyc(3);
        end
        ah <= 1'b1;
        apb(1'b1, CONFIG_OFS, 32'h00000061, rd, e);
        press(1'b1, 1'b1);
        wait_sig(0, 1'b1, 2100, n);
        check(cpu, 1'b1, "pin high push pull");
        wait_sig(0, 1'b0, 900, n);
        check(n > 200 * T - 3 && n < 200 * T + 3, 1, "fixed pulse");
        cyc(2100);
        check(ract, 1'b0, "held after pulse");
        press(1'b0, 1'b0);
        ah <= 1'b0;
        apb(1'b1, CONFIG_OFS, 32'h00000001, rd, e);
        press(1'b1, 1'b1);
        wait_sig(0, 1'b1, 2100, n);
        uv <= 1'b1;
        wait_sig(0, 1'b0, 4, n);
        cyc(2100);
        check(ract, 1'b0, "undervoltage");
        check(cpu, 1'b0, "undervoltage pin");
        press(1'b0, 1'b0);
        uv <= 1'b0;
        ov <= 1'b1;
        wait_sig(1, 1'b1, 200, n);
        check(n > 42 * T - 2 && n < 42 * T + 4, 1, "test entry");
        cyc(2);
        check(ract, 1'b1, "feedback");
        cyc(50);
        check(ract, 1'b1, "feedback hold");
        ov <= 1'b0;
        wait_sig(0, 1'b0, 4, n);
        cyc(3);
        press(1'b1, 1'b1);
        wait_sig(0, 1'b1, 200, n);
        check(n > 21 * T - 2 && n < 21 * T + 6, 1, "test hold");
        press(1'b0, 1'b0);
        cyc(10);
        check(tmode, 1'b1, "test latched");
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(2);
        check(tmode, 1'b0, "power cycle");
        end_of_test();
    end
endmodule // testbench
